// File: hw/sagc_pkg.sv
package sagc_pkg;

   // register offsets
   localparam logic [7:0] ADDR_SETTLED   = 8'h24;  // gain settled status, read only
   localparam logic [7:0] ADDR_STEP_RATE = 8'h51;  // soft-step rate control
   localparam logic [7:0] ADDR_FINE_TRIM = 8'h52;  // fine gain trim
   localparam logic [7:0] ADDR_VOL_LEFT  = 8'h53;  // left digital volume
   localparam logic [7:0] ADDR_VOL_RIGHT = 8'h54;  // right digital volume

   // field positions
   localparam int BIT_VOL_OK_L   = 7;  // left volume settled
   localparam int BIT_PGA_OK_L   = 6;  // left pga settled
   localparam int BIT_AGC_SAT_L  = 5;  // left agc saturated
   localparam int BIT_VOL_OK_R   = 3;  // right volume settled
   localparam int BIT_PGA_OK_R   = 2;  // right pga settled
   localparam int BIT_AGC_SAT_R  = 1;  // right agc saturated
   localparam int TRIM_LSB_L     = 4;  // left trim in 6:4
   localparam int TRIM_LSB_R     = 0;  // right trim in 2:0

   // reset values
   localparam logic [7:0] RST_STEP_RATE = 8'h00;
   localparam logic [7:0] RST_FINE_TRIM = 8'h00;
   localparam logic [7:0] RST_VOL       = 8'h00;

   // soft-step modes
   localparam logic [1:0] STEP_EVERY_1 = 2'h0;  // one step each sample
   localparam logic [1:0] STEP_EVERY_2 = 2'h1;  // one step each two samples

   // gain codes, half-dB units
   localparam logic signed [7:0] PGA_MUTE = 8'shFF;  // one below 0 dB means mute
   localparam logic signed [7:0] PGA_TOP  = 8'sh50;  // 40 dB
   localparam logic signed [7:0] VOL_BOT  = 8'shE8;  // -12 dB
   localparam logic signed [7:0] VOL_TOP  = 8'sh28;  // 20 dB
   localparam logic [2:0]        TRIM_TOP = 3'h4;    // -0.4 dB

   // decimation
   localparam int OSR_SINGLE = 128;  // oversampling, single rate
   localparam int OSR_DUAL   = 64;   // oversampling, dual rate
   localparam int GRP_DELAY  = 17;   // group delay in output samples
   localparam int AVG_SHIFT  = 4;    // running-average time constant

   // per-channel agc settings
   typedef struct packed {
      logic       en;         // agc on
      logic [2:0] target;     // one of eight levels
      logic [1:0] hyst;       // 0 = no hysteresis
      logic [4:0] noise_thr;  // 0 = noise detection off
      logic [6:0] max_pga;    // ceiling, half-dB
      logic [7:0] attack;     // one gain drop each attack+1 samples
      logic [7:0] decay;      // one gain rise each decay+1 samples
      logic [4:0] deb_noise;  // samples, 0 = off
      logic [3:0] deb_sig;    // samples, 0 = off
   } sagc_cfg_t;

   // channel power states
   typedef enum logic [2:0] {
      CH_OFF  = 3'b001,
      CH_ON   = 3'b010,
      CH_DOWN = 3'b100
   } sagc_pwr_t;

endpackage : sagc_pkg

// File: hw/sagc_gain_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module sagc_gain_ctrl
   import sagc_pkg::*;
#(
   parameter int CLK_PER_MOD = 8  // sys_clk cycles per modulator bit
) (
   // clock and reset
   input  wire logic               sys_clk,
   input  wire logic               sys_rst,
   // register port
   input  wire logic               reg_wr,
   input  wire logic [7:0]         reg_addr,
   input  wire logic [7:0]         reg_wdata,
   output logic      [7:0]         reg_rdata,
   // channel control
   input  wire logic               dual_rate,
   input  wire logic [1:0]         pwr_req,
   input  wire logic [6:0]         pga_set [2],
   input  wire sagc_cfg_t          agc_cfg [2],
   // modulator streams
   input  wire logic [1:0]         mod_bit,
   // results
   output logic signed [15:0]      smp_out [2],
   output logic                    smp_valid,
   output logic signed [7:0]       pga_gain [2],
   output logic signed [7:0]       vol_gain [2],
   output logic [2:0]              trim_gain [2],
   output logic [1:0]              noise_flag,
   output logic [1:0]              pwr_on
);

   // registers
   logic [7:0] rate_reg;               // soft-step rate control
   logic [7:0] trim_reg;               // fine trim
   logic [7:0] vol_reg [2];            // programmed volumes
   logic [1:0] vol_ok, pga_ok, agc_sat;  // status sources

   // rate decode
   wire  step_off  = rate_reg[1];
   wire  [7:0] osr = dual_rate ? 8'(OSR_DUAL) : 8'(OSR_SINGLE);

   // register writes
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rate_reg   <= RST_STEP_RATE;
         trim_reg   <= RST_FINE_TRIM;
         vol_reg[0] <= RST_VOL;
         vol_reg[1] <= RST_VOL;
      end else if (reg_wr) begin
         case (reg_addr)
            ADDR_STEP_RATE: rate_reg   <= reg_wdata;
            ADDR_FINE_TRIM: trim_reg   <= reg_wdata;
            ADDR_VOL_LEFT:  vol_reg[0] <= reg_wdata;
            ADDR_VOL_RIGHT: vol_reg[1] <= reg_wdata;
            default: ;
         endcase
      end
   end

   // read mux
   wire [7:0] status = {vol_ok[0], pga_ok[0], agc_sat[0], 1'b0,
                        vol_ok[1], pga_ok[1], agc_sat[1], 1'b0};
   logic [7:0] rdata_next;
   always_comb begin
      case (reg_addr)
         ADDR_SETTLED:   rdata_next = status;
         ADDR_STEP_RATE: rdata_next = rate_reg;
         ADDR_FINE_TRIM: rdata_next = trim_reg;
         ADDR_VOL_LEFT:  rdata_next = vol_reg[0];
         ADDR_VOL_RIGHT: rdata_next = vol_reg[1];
         default:        rdata_next = 8'h00;
      endcase
   end
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) reg_rdata <= 8'h00;
      else         reg_rdata <= rdata_next;
   end

   // modulator bit rate enable and sample tick
   logic [15:0] div_reg;    // sys_clk to modulator rate
   logic [7:0]  bit_cnt;    // modulator bits in window
   logic        half_reg;   // alternates each sample
   wire  mod_tick = (div_reg == 16'(CLK_PER_MOD - 1));
   wire  fs_tick  = mod_tick && (bit_cnt == osr - 8'h01);
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         div_reg  <= 16'h0000;
         bit_cnt  <= 8'h00;
         half_reg <= 1'b0;
      end else begin
         div_reg <= mod_tick ? 16'h0000 : div_reg + 16'h0001;
         if (mod_tick) bit_cnt <= fs_tick ? 8'h00 : bit_cnt + 8'h01;
         if (fs_tick)  half_reg <= ~half_reg;
      end
   end
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) smp_valid <= 1'b0;
      else         smp_valid <= fs_tick;
   end

   // step permission for this sample
   wire step_go = fs_tick && (rate_reg[1:0] == STEP_EVERY_1 ||
                              (rate_reg[1:0] == STEP_EVERY_2 && half_reg));

   // move one half-dB toward target, or jump when stepping is off
   function automatic logic signed [7:0] step_to(input logic signed [7:0] cur,
                                                 input logic signed [7:0] tgt,
                                                 input logic jump);
      if (jump || cur == tgt) step_to = tgt;
      else if (cur < tgt)     step_to = cur + 8'sh01;
      else                    step_to = cur - 8'sh01;
   endfunction : step_to

   // target amplitude for agc level codes
   function automatic logic [15:0] target_amp(input logic [2:0] code);
      case (code)
         3'h0:    target_amp = 16'h4405;  // -5.5 dB
         3'h1:    target_amp = 16'h32F5;
         3'h2:    target_amp = 16'h287A;
         3'h3:    target_amp = 16'h2027;
         3'h4:    target_amp = 16'h198A;
         3'h5:    target_amp = 16'h1215;
         3'h6:    target_amp = 16'h0CCD;
         default: target_amp = 16'h0814;  // -24 dB
      endcase
   endfunction : target_amp

   // per-channel datapath
   for (genvar c = 0; c < 2; c++) begin : g_ch
      sagc_pwr_t         st_reg, st_next;     // power state
      logic [7:0]        ones_reg;            // ones in window
      logic signed [15:0] dly [GRP_DELAY];    // group-delay line
      logic [15:0]       avg_reg;             // running |x| average
      logic [6:0]        agc_reg;             // agc gain
      logic [7:0]        tc_reg;              // attack/decay timer
      logic [4:0]        deb_reg;             // debounce counter
      logic              noise_reg;           // noise class

      // window sum to a signed sample
      wire [7:0] ones_nx = ones_reg + {7'h00, mod_bit[c]};
      wire signed [15:0] raw = dual_rate ?
                16'((ones_nx - 8'(OSR_DUAL / 2)) << 9) :
                16'((ones_nx - 8'(OSR_SINGLE / 2)) << 8);
      wire signed [15:0] x    = dly[GRP_DELAY - 1];
      wire [15:0]        absx = x[15] ? 16'(-x) : 16'(x);
      wire signed [16:0] diff = $signed({1'b0, absx}) - $signed({1'b0, avg_reg});
      wire [15:0] avg_nx = 16'($signed({1'b0, avg_reg}) + (diff >>> AVG_SHIFT));

      // noise threshold and hysteresis window
      wire        nz_en = (agc_cfg[c].noise_thr != 5'h00);
      wire [15:0] thr   = 16'h040C >> ((agc_cfg[c].noise_thr - 5'h01) / 5'h03);
      wire [15:0] hys   = (agc_cfg[c].hyst == 2'h0) ? 16'h0000 :
                          (thr >> (3'h4 - {1'b0, agc_cfg[c].hyst}));
      wire        below = avg_reg < (thr - hys);
      wire        above = avg_reg > (thr + hys);
      wire        flip  = noise_reg ? above : below;
      wire [4:0]  deb_n = noise_reg ? {1'b0, agc_cfg[c].deb_sig} : agc_cfg[c].deb_noise;
      wire [15:0] tgt   = target_amp(agc_cfg[c].target);

      // pga and volume targets
      // manual gain held to the pga range, volume code held to its range
      wire signed [7:0] pga_man  = (pga_set[c] > 7'(PGA_TOP)) ? PGA_TOP :
                                   $signed({1'b0, pga_set[c]});
      wire signed [7:0] pga_tgt = (st_reg != CH_ON) ? PGA_MUTE :
                      agc_cfg[c].en ? $signed({1'b0, agc_reg}) :
                      pga_man;
      wire signed [7:0] vol_raw  = $signed({vol_reg[c][6], vol_reg[c][6:0]});
      wire signed [7:0] vol_prog = (vol_raw > VOL_TOP) ? VOL_TOP :
                                   (vol_raw < VOL_BOT) ? VOL_BOT : vol_raw;
      wire signed [7:0] vol_tgt  = (st_reg != CH_ON) ? VOL_BOT : vol_prog;
      wire [2:0] trim_f = trim_reg[(c == 0 ? TRIM_LSB_L : TRIM_LSB_R) +: 3];

      // power state machine
      always_comb begin
         case (st_reg)
            CH_OFF:  st_next = pwr_req[c] ? CH_ON : CH_OFF;
            CH_ON:   st_next = pwr_req[c] ? CH_ON : CH_DOWN;
            CH_DOWN: st_next = (pga_gain[c] == PGA_MUTE && vol_gain[c] == VOL_BOT)
                               ? CH_OFF : CH_DOWN;
            default: st_next = CH_OFF;
         endcase
      end
      always_ff @(posedge sys_clk or posedge sys_rst) begin
         if (sys_rst) st_reg <= CH_OFF;
         else         st_reg <= st_next;
      end

      // decimator: count ones, delay for fixed latency
      always_ff @(posedge sys_clk or posedge sys_rst) begin
         if (sys_rst) begin
            ones_reg <= 8'h00;
            for (int i = 0; i < GRP_DELAY; i++) dly[i] <= 16'sh0000;
         end else if (mod_tick) begin
            ones_reg <= fs_tick ? 8'h00 : ones_nx;
            if (fs_tick) begin
               dly[0] <= (st_reg == CH_OFF) ? 16'sh0000 : raw;
               for (int i = 1; i < GRP_DELAY; i++) dly[i] <= dly[i - 1];
            end
         end
      end

      // gain stepping and outputs
      always_ff @(posedge sys_clk or posedge sys_rst) begin
         if (sys_rst) begin
            pga_gain[c]  <= PGA_MUTE;
            vol_gain[c]  <= 8'sh00;
            trim_gain[c] <= 3'h0;
            smp_out[c]   <= 16'sh0000;
            pwr_on[c]    <= 1'b0;
         end else begin
            pwr_on[c] <= (st_next != CH_OFF);
            if (step_go || (step_off && fs_tick)) begin
               pga_gain[c] <= step_to(pga_gain[c], pga_tgt, step_off);
               vol_gain[c] <= step_to(vol_gain[c], vol_tgt, step_off);
            end
            if (fs_tick) begin
               trim_gain[c] <= (trim_f > TRIM_TOP) ? TRIM_TOP : trim_f;
               smp_out[c]   <= x;
            end
         end
      end

      // agc: average, classify, adjust
      always_ff @(posedge sys_clk or posedge sys_rst) begin
         if (sys_rst) begin
            avg_reg   <= 16'h0000;
            agc_reg   <= 7'h00;
            tc_reg    <= 8'h00;
            deb_reg   <= 5'h00;
            noise_reg <= 1'b0;
         end else if (fs_tick) begin
            avg_reg <= avg_nx;
            // debounced class change
            if (!nz_en) begin
               noise_reg <= 1'b0;
               deb_reg   <= 5'h00;
            end else if (!flip) begin
               deb_reg <= 5'h00;
            end else if (deb_reg >= deb_n) begin
               noise_reg <= ~noise_reg;
               deb_reg   <= 5'h00;
            end else begin
               deb_reg <= deb_reg + 5'h01;
            end
            // gain decision once per sample
            if (noise_reg) begin
               if (agc_reg != 7'h00) agc_reg <= agc_reg - 7'h01;
               tc_reg <= 8'h00;
            end else if (agc_reg > agc_cfg[c].max_pga) begin
               agc_reg <= agc_cfg[c].max_pga;
            end else if (avg_reg > tgt) begin
               tc_reg <= (tc_reg >= agc_cfg[c].attack) ? 8'h00 : tc_reg + 8'h01;
               if (tc_reg >= agc_cfg[c].attack && agc_reg != 7'h00)
                  agc_reg <= agc_reg - 7'h01;
            end else if (avg_reg < tgt) begin
               tc_reg <= (tc_reg >= agc_cfg[c].decay) ? 8'h00 : tc_reg + 8'h01;
               if (tc_reg >= agc_cfg[c].decay && agc_reg < agc_cfg[c].max_pga &&
                   agc_reg < 7'(PGA_TOP))
                  agc_reg <= agc_reg + 7'h01;
            end else begin
               tc_reg <= 8'h00;
            end
         end
      end

      // status sources
      assign vol_ok[c]  = (vol_gain[c] == vol_prog);
      assign pga_ok[c]  = (pga_gain[c] == pga_tgt);
      assign agc_sat[c] = agc_cfg[c].en && !noise_reg && avg_reg < tgt &&
                          agc_reg >= agc_cfg[c].max_pga;
      always_ff @(posedge sys_clk or posedge sys_rst) begin
         if (sys_rst) noise_flag[c] <= 1'b0;
         else         noise_flag[c] <= noise_reg && agc_cfg[c].en;
      end
   end

endmodule : sagc_gain_ctrl

`default_nettype wire

// File: sim/sagc_mic_model.sv
`timescale 1ns/1ps
`default_nettype none

module sagc_mic_model #(
   parameter int CLK_PER_MOD = 8  // clocks per modulator bit
) (
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   // ones per 128 bits, per channel
   input  wire logic [7:0] level [2],
   // modulator bits toward the converter
   output logic      [1:0] mod_bit
);
   int         div;    // clocks within one modulator bit
   logic [6:0] phase;  // position in the 128-bit pattern

   // one new bit per modulator period, so any 128 bits hold exactly level ones
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         div   <= 0;
         phase <= 7'h00;
      end else if (div == CLK_PER_MOD - 1) begin
         div   <= 0;
         phase <= phase + 7'h01;
      end else begin
         div <= div + 1;
      end
   end

   // density pattern, 64 ones is silence at single rate; dual-rate windows alternate all ones and all zeros
   assign mod_bit[0] = {1'b0, phase} < level[0];
   assign mod_bit[1] = {1'b0, phase} < level[1];
endmodule : sagc_mic_model

`default_nettype wire

// File: sim/sagc_gain_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module sagc_gain_monitor
   import sagc_pkg::*;
#(
   parameter int CLK_PER_MOD = 8  // clocks per modulator bit
) (
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              sys_rst,
   // register writes
   input  wire logic              reg_wr,
   input  wire logic [7:0]        reg_addr,
   input  wire logic [7:0]        reg_wdata,
   // controls
   input  wire logic              dual_rate,
   input  wire logic [1:0]        pwr_req,
   input  wire sagc_cfg_t         agc_cfg [2],
   // results
   input  wire logic              smp_valid,
   input  wire logic signed [7:0] pga_gain [2],
   input  wire logic signed [7:0] vol_gain [2],
   input  wire logic [2:0]        trim_gain [2],
   input  wire logic [1:0]        noise_flag,
   input  wire logic [1:0]        pwr_on
);
   logic [1:0]  rate_q;   // stepping mode last written
   logic [15:0] gap_cnt;  // clocks since last sample pulse
   logic        gap_ok;   // gap timed wholly at single rate

   // mirror of the stepping mode field
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) rate_q <= 2'h0;
      else if (reg_wr && reg_addr == ADDR_STEP_RATE) rate_q <= reg_wdata[1:0];
   end

   // sample spacing counter, dropped whenever dual rate shows
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         gap_cnt <= 16'h0000;
         gap_ok  <= 1'b0;
      end else begin
         gap_cnt <= smp_valid ? 16'h0001 : gap_cnt + 16'h0001;
         gap_ok  <= dual_rate ? 1'b0 : (smp_valid | gap_ok);
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   a_pga_reset_mute: assert property ($fell(sys_rst) |-> pga_gain[0] == PGA_MUTE
      && pga_gain[1] == PGA_MUTE) else $error("pga not muted after reset");
   a_pga_on_tick: assert property ($changed(pga_gain[0]) |-> smp_valid)
      else $error("pga moved off a sample tick");
   a_pga_step_one: assert property (!rate_q[1] && $changed(pga_gain[0]) |->
      pga_gain[0] == $past(pga_gain[0]) + 8'sh01 || pga_gain[0] == $past(pga_gain[0]) - 8'sh01)
      else $error("pga step not one code");
   a_vol_step_one: assert property (!rate_q[1] && $changed(vol_gain[0]) |->
      vol_gain[0] == $past(vol_gain[0]) + 8'sh01 || vol_gain[0] == $past(vol_gain[0]) - 8'sh01)
      else $error("volume step not one code");
   a_vol_in_range: assert property (vol_gain[0] >= VOL_BOT && vol_gain[0] <= VOL_TOP)
      else $error("volume out of range");
   a_trim_in_range: assert property (trim_gain[0] <= TRIM_TOP && trim_gain[1] <= TRIM_TOP)
      else $error("trim out of range");
   a_pwr_up_next: assert property ($rose(pwr_req[0]) && !pwr_on[0] |=> pwr_on[0])
      else $error("channel did not power up");
   a_pwr_down_floor: assert property ($fell(pwr_on[0]) |->
      pga_gain[0] == PGA_MUTE && vol_gain[0] == VOL_BOT) else $error("power-down not ramped");
   a_agc_ceiling: assert property (agc_cfg[1].en && pga_gain[1] > $past(pga_gain[1]) |->
      pga_gain[1] <= $signed({1'b0, agc_cfg[1].max_pga})) else $error("agc above ceiling");
   a_noise_ramp_down: assert property (noise_flag[1] && agc_cfg[1].en
      && $past(pga_gain[1]) > 8'sh00 && $changed(pga_gain[1]) |->
      pga_gain[1] < $past(pga_gain[1])) else $error("noise gain not falling");
   a_smp_period: assert property (smp_valid && gap_ok |->
      gap_cnt == CLK_PER_MOD * OSR_SINGLE) else $error("sample spacing wrong");
endmodule : sagc_gain_monitor

bind sagc_gain_ctrl sagc_gain_monitor #(.CLK_PER_MOD(CLK_PER_MOD)) u_mon (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .dual_rate(dual_rate), .pwr_req(pwr_req), .agc_cfg(agc_cfg),
   .smp_valid(smp_valid), .pga_gain(pga_gain), .vol_gain(vol_gain), .trim_gain(trim_gain),
   .noise_flag(noise_flag), .pwr_on(pwr_on));

`default_nettype wire

// File: sim/stereo_adc_gain_control_tb.sv
`timescale 1ns/1ps
`default_nettype none

module stereo_adc_gain_control_tb
   import sagc_pkg::*;
;
   localparam int CPM = 1;  // short modulator period
   logic               sys_clk, sys_rst, reg_wr, dual_rate, smp_valid;  // control
   logic [7:0]         reg_addr, reg_wdata, reg_rdata, rd;  // register port, last read
   logic [1:0]         pwr_req, mod_bit, noise_flag, pwr_on;  // per-channel bits
   logic [6:0]         pga_set [2];    // manual pga gain
   sagc_cfg_t          agc_cfg [2];    // agc settings
   logic [7:0]         level [2];      // mic ones per 128 bits
   logic signed [15:0] smp_out [2];    // decimated samples
   logic signed [7:0]  pga_gain [2];   // applied pga
   logic signed [7:0]  vol_gain [2];   // applied volume
   logic [2:0]         trim_gain [2];  // applied trim
   int                 err_total, compares;  // tallies
   time                t0;             // pulse timestamp

   sagc_mic_model #(.CLK_PER_MOD(CPM)) u_mic (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .level(level), .mod_bit(mod_bit));
   sagc_gain_ctrl #(.CLK_PER_MOD(CPM)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .dual_rate(dual_rate), .pwr_req(pwr_req), .pga_set(pga_set), .agc_cfg(agc_cfg),
      .mod_bit(mod_bit), .smp_out(smp_out), .smp_valid(smp_valid), .pga_gain(pga_gain),
      .vol_gain(vol_gain), .trim_gain(trim_gain), .noise_flag(noise_flag), .pwr_on(pwr_on));

   // 100 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // compare and tally
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one write cycle, strobe held for one edge
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_wr    = 1'b1;
      reg_addr  = a;
      reg_wdata = d;
      @(negedge sys_clk);
      reg_wr = 1'b0;
   endtask : reg_write

   // registered read, data one edge after address
   task automatic reg_rd(input logic [7:0] a);
      @(negedge sys_clk);
      reg_addr = a;
      @(negedge sys_clk);
      rd = reg_rdata;
   endtask : reg_rd

   // wait for n sample pulses
   task automatic samples(input int n);
      repeat (n) @(posedge smp_valid);
      @(negedge sys_clk);
   endtask : samples

   // reset values, unmapped read, muted pga
   task automatic t_reset();
      for (int a = 'h51; a <= 'h54; a++) begin
         reg_rd(8'(a));
         chk(rd, 16'h0000);
      end
      reg_rd(8'h00);
      chk(rd, 16'h0000);
      chk(pga_gain[0], 16'hFFFF);
      chk(pga_gain[1], 16'hFFFF);
   endtask : t_reset

   // volume stepping in all three modes, trim clamp
   task automatic t_volume();
      pwr_req[0] = 1'b1;
      reg_write(ADDR_VOL_LEFT, 8'h04);
      samples(8);
      chk(vol_gain[0], 16'h0004);
      reg_rd(ADDR_SETTLED);
      chk(rd[7], 1'b1);
      reg_write(ADDR_STEP_RATE, {6'h00, STEP_EVERY_2});
      reg_write(ADDR_VOL_LEFT, 8'h7C);
      samples(5);
      reg_rd(ADDR_SETTLED);
      chk(rd[7], 1'b0);
      chk(vol_gain[0] > 8'sh00, 1'b1);
      samples(14);
      chk(vol_gain[0], 16'hFFFC);
      reg_write(ADDR_STEP_RATE, 8'h02);
      reg_write(ADDR_VOL_LEFT, 8'h30);
      samples(2);
      chk(vol_gain[0], 16'h0028);
      reg_write(ADDR_FINE_TRIM, 8'h71);
      samples(2);
      chk(trim_gain[0], 16'h0004);
      chk(trim_gain[1], 16'h0001);
   endtask : t_volume

   // manual pga with agc off, settled flag, one channel only
   task automatic t_pga();
      reg_write(ADDR_STEP_RATE, {6'h00, STEP_EVERY_1});
      pga_set[0] = 7'h0A;
      samples(14);
      chk(pga_gain[0], 16'h000A);
      reg_rd(ADDR_SETTLED);
      chk(rd[6], 1'b1);
      chk(pwr_on, 16'h0001);
      reg_write(ADDR_STEP_RATE, 8'h02);
      pga_set[0] = 7'h7F;
      samples(2);
      chk(pga_gain[0], 16'h0050);
      reg_write(ADDR_STEP_RATE, {6'h00, STEP_EVERY_1});
   endtask : t_pga

   // delayed samples, off channel zero, dual-rate spacing
   task automatic t_smp();
      level[0] = 8'h80;
      samples(20);
      chk(smp_out[0], 16'h4000);
      chk(smp_out[1], 16'h0000);
      dual_rate = 1'b1;
      samples(24);
      chk(smp_out[0], 16'h4000);
      @(posedge smp_valid);
      t0 = $time;
      @(posedge smp_valid);
      chk(16'(($time - t0) / 10), 16'(CPM * OSR_DUAL));
      @(negedge sys_clk);
      dual_rate = 1'b0;
      samples(2);
   endtask : t_smp

   // power-down ramps before the channel turns off
   task automatic t_down();
      pwr_req[0] = 1'b0;
      for (int i = 0; i < 100 && pwr_on[0] === 1'b1; i++) samples(1);
      chk(pwr_on[0], 1'b0);
      chk(pga_gain[0], 16'hFFFF);
      chk(vol_gain[0], 16'hFFE8);
   endtask : t_down

   // agc: quiet signal hits ceiling, silence ramps to 0 dB, loud clears noise
   task automatic t_agc();
      agc_cfg[1] = '{en: 1'b1, target: 3'h7, hyst: 2'h0, noise_thr: 5'h01, max_pga: 7'h06,
                     attack: 8'h01, decay: 8'h01, deb_noise: 5'h00, deb_sig: 4'h00};
      level[1]   = 8'h45;
      pwr_req[1] = 1'b1;
      samples(100);
      chk(pga_gain[1], 16'h0006);
      reg_rd(ADDR_SETTLED);
      chk(rd[3:1], 16'h0007);
      level[1] = 8'h40;
      samples(100);
      chk(noise_flag[1], 1'b1);
      chk(pga_gain[1], 16'h0000);
      level[1] = 8'h80;
      samples(100);
      chk(noise_flag[1], 1'b0);
   endtask : t_agc

   // verdict and end of run
   task automatic test_done();
      if (err_total == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : test_done

   // main sequence
   initial begin
      err_total = 0;
      compares  = 0;
      {sys_rst, reg_wr, dual_rate, reg_addr, reg_wdata, pwr_req} = {3'b100, 18'h00000};
      pga_set   = '{7'h00, 7'h00};
      agc_cfg   = '{'0, '0};
      level     = '{8'h40, 8'h40};
      repeat (16) @(negedge sys_clk);
      sys_rst = 1'b0;
      t_reset();
      t_volume();
      t_pga();
      t_smp();
      t_down();
      t_agc();
      test_done();
   end

   // hang guard
   initial begin
      repeat (97000) @(posedge sys_clk);
      err_total++;
      test_done();
   end
endmodule : stereo_adc_gain_control_tb

`default_nettype wire
